// ==== dram_rank_model.sv ====
// behavioural model of the dram ranks answering read bursts and write leveling
`timescale 1ns/100ps
`default_nettype none
module dram_rank_model
#(
  parameter int EDGE = 80
)
(
  input wire logic i_core_clk,
  input wire logic i_rd_cmd,
  input wire logic i_sweep,
  input wire logic [9:0] i_wdqs_dly,
  input wire logic i_level_mode,
  input wire logic [1:0] i_dqs_set,
  input wire logic [1:0] i_dq_set,
  output logic [1:0] o_dqs,
  output logic [1:0] o_dq,
  output logic [1:0] o_wdqs_rise
);
  logic [1:0] phase_r = 2'h0;

  always @(posedge i_core_clk)
  begin
    phase_r <= phase_r + 2'h1;
  end

  // strobe is only driven while reads run; idle shows the inverse so a stale capture never matches
  assign o_dqs = i_rd_cmd ? i_dqs_set : ~i_dqs_set;
  // in leveling the dq lines carry the clock state at each strobe rise
  assign o_wdqs_rise = (i_level_mode && phase_r == 2'h3) ? 2'h3 : 2'h0;
  // in a sweep the clock edge sits at EDGE units of lane 0 strobe delay
  assign o_dq = i_level_mode ? (i_sweep ? {2{i_wdqs_dly >= 10'(EDGE)}} : i_dq_set) : ~i_dq_set;
endmodule : dram_rank_model
`default_nettype wire

// ==== dram_read_burst.sv ====
// expands one processor read into a burst of dram reads and keeps the last strobe sample
`timescale 1ns/100ps
`default_nettype none
module dram_read_burst
  import phy_train_pkg::*;
#(
  parameter int BURST = READS_PER_ACCESS
)
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [1:0] i_dqs,
  output logic o_rd_cmd,
  output logic o_busy,
  output logic [1:0] o_dqs_last
);
  initial
  begin
    if (BURST < 1 || BURST > 15)
      $error("dram_read_burst: BURST out of range");
  end

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [1:0] last_r;
  logic [1:0] last_nxt;
  logic cmd_r;
  logic cmd_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    last_nxt = last_r;
    cmd_nxt = 1'b0;
    if (cnt_r != 4'h0)
    begin
      cmd_nxt = 1'b1;
      cnt_nxt = cnt_r - 4'h1;
      // only the final read of the burst may hold the preamble window
      if (cnt_r == 4'h1)
        last_nxt = i_dqs; // RULE11
    end
    else if (i_start)
      cnt_nxt = 4'(BURST); // RULE11
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cnt_r <= 4'h0;
      last_r <= 2'h0;
      cmd_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      last_r <= last_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  assign o_rd_cmd = cmd_r;
  assign o_busy = (cnt_r != 4'h0);
  assign o_dqs_last = last_r;

  property p_burst_len;
    @(posedge i_core_clk) disable iff (i_rst)
    (i_start && cnt_r == 4'h0) |=> (cnt_r == 4'(BURST));
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst not loaded"); // RULE11
endmodule : dram_read_burst
`default_nettype wire

// ==== phy_train_pkg.sv ====
// constants and carrier types for the ddr phy delay-training register block
// ****************************************
// Operation
// ****************************************
// Operation
// [RULE1] train every rank and both lanes separately
// [RULE2] receive-enable delay is coarse*64 plus fine
// [RULE3] write-strobe delay is coarse*64 plus fine
// [RULE4] write-data delay is coarse*64 plus fine
// [RULE5] receive-enable fine out of band sets flags
// [RULE6] write-strobe fine out of band sets flags
// [RULE7] write-data fine out of band sets flags
// [RULE8] sampled read strobe shown per lane
// [RULE9] leveling data sample latched on strobe rise
// [RULE10] firmware averages several strobe samples
// [RULE11] one cpu read makes four dram reads
// [RULE12] firmware sets command spacing one during training
// [RULE13] receive-enable sweep steps, plus 32, minus 128
// [RULE14] leveling entry sequence with pad config masks
// [RULE15] sweep strobe delay up until data rises
// [RULE16] leveling exit sequence reverses entry
// [RULE17] coarse leveling moves strobe in whole clocks
// [RULE18] program per-lane average over ranks
// [RULE19] firmware disables caching and flushes bridge
// [RULE20] read training centres reference and strobe delay
// [RULE21] read strobe delay is seven-bit field
// [RULE22] reference voltage six-bit field at bits 7:2
// [RULE23] sequencer steps by one and saturates
package phy_train_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_REF_LANE0 = 16'h0014;
  localparam logic [15:0] OFS_REF_LANE1 = 16'h0024;
  localparam logic [15:0] OFS_SAMPLE = 16'h0034;
  localparam logic [15:0] OFS_FINE_LANE1 = 16'h0038;
  localparam logic [15:0] OFS_FINE_LANE0 = 16'h003C;
  localparam logic [15:0] OFS_RDQS_LANE1 = 16'h0058;
  localparam logic [15:0] OFS_RDQS_LANE0 = 16'h005C;
  localparam logic [15:0] OFS_COARSE = 16'h0070;
  localparam logic [15:0] OFS_DEAD_BAND = 16'h007C;
  localparam logic [15:0] OFS_PAD_CFG = 16'h009C;
  localparam logic [15:0] OFS_LEVEL_CTRL = 16'h5830;
  localparam logic [15:0] OFS_READ_GEN = 16'h0100;

  // ****************************************
  // field layout
  // ****************************************
  localparam int FINE_W = 6;
  localparam int COARSE_W = 4;
  localparam int DELAY_W = 10;
  localparam int FINE_RCVEN_LSB = 24;
  localparam int FINE_WDQS_LSB = 16;
  localparam int FINE_WDQ_LSB = 8;
  // coarse field lsb: [lane][kind], kind 0 rcven, 1 wdqs, 2 wdq
  localparam int CRS_RCVEN_L0 = 8;
  localparam int CRS_WDQS_L0 = 4;
  localparam int CRS_WDQ_L0 = 0;
  localparam int CRS_RCVEN_L1 = 20;
  localparam int CRS_WDQS_L1 = 16;
  localparam int CRS_WDQ_L1 = 12;
  localparam int COARSE_SCALE_SH = 6;
  localparam int RDQS_W = 7;
  localparam int REF_LSB = 2;
  localparam int REF_W = 6;
  localparam int SMP_DQS_L0 = 0;
  localparam int SMP_DQS_L1 = 1;
  localparam int SMP_DQ_L0 = 8;
  localparam int SMP_DQ_L1 = 9;
  localparam int LEVEL_EN_BIT = 16;
  localparam int READ_GEN_RANK_BIT = 0;

  // ****************************************
  // dead-band limits and reset values
  // ****************************************
  localparam logic [5:0] DEAD_LOW = 6'h12;
  localparam logic [5:0] DEAD_HIGH = 6'h34;
  localparam int READS_PER_ACCESS = 4;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] dqs;
    logic [1:0] dq;
  } pad_sample_t;

  typedef struct packed {
    logic [DELAY_W-1:0] rcven;
    logic [DELAY_W-1:0] wdqs;
    logic [DELAY_W-1:0] wdq;
    logic [RDQS_W-1:0] rdqs;
    logic [REF_W-1:0] vref;
  } lane_delay_t;

endpackage : phy_train_pkg

// ==== phy_train_regs.sv ====
// ddr phy delay-training register block with sample capture and delay outputs
`timescale 1ns/100ps
`default_nettype none
module phy_train_regs
  import phy_train_pkg::*;
#(
  parameter int LANES = 2
)
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [1:0] i_dqs_sample,
  input wire logic [1:0] i_dq_level,
  input wire logic [1:0] i_wdqs_rise,
  output logic o_dram_rd_cmd,
  output logic o_dram_rd_rank,
  output logic o_level_mode,
  output phy_train_pkg::lane_delay_t o_lane0,
  output phy_train_pkg::lane_delay_t o_lane1
);
  initial
  begin
    if (LANES != 2)
      $error("phy_train_regs: two byte lanes only");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [DELAY_W-1:0] full_delay(input logic [COARSE_W-1:0] c, input logic [FINE_W-1:0] f);
    full_delay = (DELAY_W'(c) << COARSE_SCALE_SH) + DELAY_W'(f);
  endfunction : full_delay

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs, input logic w);
    wr_hit = w && (a == ofs);
  endfunction : wr_hit

  // ****************************************
  // register state
  // ****************************************
  logic [31:0] fine0_r, fine0_nxt;
  logic [31:0] fine1_r, fine1_nxt;
  logic [31:0] coarse_r, coarse_nxt;
  logic [31:0] dead_r, dead_nxt;
  logic [31:0] pad_r, pad_nxt;
  logic [31:0] lvl_r, lvl_nxt;
  logic [31:0] ref0_r, ref0_nxt;
  logic [31:0] ref1_r, ref1_nxt;
  logic [31:0] rdqs0_r, rdqs0_nxt;
  logic [31:0] rdqs1_r, rdqs1_nxt;
  logic rank_r, rank_nxt;
  logic [1:0] dq_lat_r, dq_lat_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic burst_start;
  logic burst_cmd;
  logic [1:0] dqs_last;
  lane_delay_t lane0_r, lane0_nxt;
  lane_delay_t lane1_r, lane1_nxt;
  logic cmd_r;
  logic rank_o_r;
  logic lvl_o_r;

  always_comb
  begin
    fine0_nxt = fine0_r;
    fine1_nxt = fine1_r;
    coarse_nxt = coarse_r;
    dead_nxt = dead_r;
    pad_nxt = pad_r;
    lvl_nxt = lvl_r;
    ref0_nxt = ref0_r;
    ref1_nxt = ref1_r;
    rdqs0_nxt = rdqs0_r;
    rdqs1_nxt = rdqs1_r;
    rank_nxt = rank_r;
    if (wr_hit(i_addr, OFS_FINE_LANE0, i_wr)) fine0_nxt = i_wdata;
    if (wr_hit(i_addr, OFS_FINE_LANE1, i_wr)) fine1_nxt = i_wdata;
    if (wr_hit(i_addr, OFS_COARSE, i_wr)) coarse_nxt = i_wdata;
    if (wr_hit(i_addr, OFS_DEAD_BAND, i_wr)) dead_nxt = i_wdata;
    if (wr_hit(i_addr, OFS_PAD_CFG, i_wr)) pad_nxt = i_wdata;
    if (wr_hit(i_addr, OFS_LEVEL_CTRL, i_wr)) lvl_nxt = i_wdata;
    // only the reference field is stored; other bits read zero
    if (wr_hit(i_addr, OFS_REF_LANE0, i_wr)) ref0_nxt = i_wdata & (32'h0000_003F << REF_LSB); // RULE22
    if (wr_hit(i_addr, OFS_REF_LANE1, i_wr)) ref1_nxt = i_wdata & (32'h0000_003F << REF_LSB); // RULE22
    if (wr_hit(i_addr, OFS_RDQS_LANE0, i_wr)) rdqs0_nxt = {25'h0, i_wdata[RDQS_W-1:0]}; // RULE21
    if (wr_hit(i_addr, OFS_RDQS_LANE1, i_wr)) rdqs1_nxt = {25'h0, i_wdata[RDQS_W-1:0]}; // RULE21
    if (wr_hit(i_addr, OFS_READ_GEN, i_wr)) rank_nxt = i_wdata[READ_GEN_RANK_BIT];
  end

  // a write to the read-generate register starts a four-read burst
  assign burst_start = wr_hit(i_addr, OFS_READ_GEN, i_wr);

  dram_read_burst #(.BURST(READS_PER_ACCESS)) u_burst (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(burst_start),
    .i_dqs(i_dqs_sample),
    .o_rd_cmd(burst_cmd),
    .o_busy(),
    .o_dqs_last(dqs_last)
  );

  // ****************************************
  // leveling data sample on strobe rise
  // ****************************************
  always_comb
  begin
    dq_lat_nxt = dq_lat_r;
    for (int l = 0; l < 2; l++)
      if (lvl_r[LEVEL_EN_BIT] && i_wdqs_rise[l])
        dq_lat_nxt[l] = i_dq_level[l]; // RULE9
  end

  // ****************************************
  // read data, one cycle after the strobe
  // ****************************************
  always_comb
  begin
    rdata_nxt = RST_ZERO;
    if (i_rd)
    begin
      unique case (i_addr)
        OFS_SAMPLE:
        begin
          rdata_nxt[SMP_DQS_L0] = dqs_last[0]; // RULE8
          rdata_nxt[SMP_DQS_L1] = dqs_last[1]; // RULE8
          rdata_nxt[SMP_DQ_L0] = dq_lat_r[0]; // RULE9
          rdata_nxt[SMP_DQ_L1] = dq_lat_r[1]; // RULE9
        end
        OFS_FINE_LANE0: rdata_nxt = fine0_r;
        OFS_FINE_LANE1: rdata_nxt = fine1_r;
        OFS_COARSE: rdata_nxt = coarse_r;
        OFS_DEAD_BAND: rdata_nxt = dead_r;
        OFS_PAD_CFG: rdata_nxt = pad_r;
        OFS_LEVEL_CTRL: rdata_nxt = lvl_r;
        OFS_REF_LANE0: rdata_nxt = ref0_r;
        OFS_REF_LANE1: rdata_nxt = ref1_r;
        OFS_RDQS_LANE0: rdata_nxt = rdqs0_r;
        OFS_RDQS_LANE1: rdata_nxt = rdqs1_r;
        OFS_READ_GEN: rdata_nxt = {31'h0, rank_r};
        default: rdata_nxt = RST_ZERO;
      endcase
    end
  end

  // ****************************************
  // combined delays driven to the pads
  // ****************************************
  always_comb
  begin
    lane0_nxt.rcven = full_delay(coarse_r[CRS_RCVEN_L0 +: COARSE_W], fine0_r[FINE_RCVEN_LSB +: FINE_W]); // RULE2
    lane1_nxt.rcven = full_delay(coarse_r[CRS_RCVEN_L1 +: COARSE_W], fine1_r[FINE_RCVEN_LSB +: FINE_W]); // RULE2
    lane0_nxt.wdqs = full_delay(coarse_r[CRS_WDQS_L0 +: COARSE_W], fine0_r[FINE_WDQS_LSB +: FINE_W]); // RULE3
    lane1_nxt.wdqs = full_delay(coarse_r[CRS_WDQS_L1 +: COARSE_W], fine1_r[FINE_WDQS_LSB +: FINE_W]); // RULE3
    lane0_nxt.wdq = full_delay(coarse_r[CRS_WDQ_L0 +: COARSE_W], fine0_r[FINE_WDQ_LSB +: FINE_W]); // RULE4
    lane1_nxt.wdq = full_delay(coarse_r[CRS_WDQ_L1 +: COARSE_W], fine1_r[FINE_WDQ_LSB +: FINE_W]); // RULE4
    lane0_nxt.rdqs = rdqs0_r[RDQS_W-1:0];
    lane1_nxt.rdqs = rdqs1_r[RDQS_W-1:0];
    lane0_nxt.vref = ref0_r[REF_LSB +: REF_W];
    lane1_nxt.vref = ref1_r[REF_LSB +: REF_W];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      fine0_r <= RST_ZERO;
      fine1_r <= RST_ZERO;
      coarse_r <= RST_ZERO;
      dead_r <= RST_ZERO;
      pad_r <= RST_ZERO;
      lvl_r <= RST_ZERO;
      ref0_r <= RST_ZERO;
      ref1_r <= RST_ZERO;
      rdqs0_r <= RST_ZERO;
      rdqs1_r <= RST_ZERO;
      rank_r <= 1'b0;
      dq_lat_r <= 2'h0;
      rdata_r <= RST_ZERO;
      lane0_r <= '0;
      lane1_r <= '0;
      cmd_r <= 1'b0;
      rank_o_r <= 1'b0;
      lvl_o_r <= 1'b0;
    end
    else
    begin
      fine0_r <= fine0_nxt;
      fine1_r <= fine1_nxt;
      coarse_r <= coarse_nxt;
      dead_r <= dead_nxt;
      pad_r <= pad_nxt;
      lvl_r <= lvl_nxt;
      ref0_r <= ref0_nxt;
      ref1_r <= ref1_nxt;
      rdqs0_r <= rdqs0_nxt;
      rdqs1_r <= rdqs1_nxt;
      rank_r <= rank_nxt;
      dq_lat_r <= dq_lat_nxt;
      rdata_r <= rdata_nxt;
      lane0_r <= lane0_nxt;
      lane1_r <= lane1_nxt;
      cmd_r <= burst_cmd;
      rank_o_r <= rank_r;
      lvl_o_r <= lvl_r[LEVEL_EN_BIT];
    end
  end

  assign o_rdata = rdata_r;
  assign o_lane0 = lane0_r;
  assign o_lane1 = lane1_r;
  assign o_dram_rd_cmd = cmd_r;
  assign o_dram_rd_rank = rank_o_r;
  assign o_level_mode = lvl_o_r;

  // ****************************************
  // checks
  // ****************************************
  sequence s_fine0_write;
    i_wr && i_addr == OFS_FINE_LANE0;
  endsequence

  property p_rcven_l0;
    @(posedge i_core_clk) disable iff (i_rst)
    s_fine0_write ##1 !(i_wr && (i_addr == OFS_FINE_LANE0 || i_addr == OFS_COARSE))
      |=> (o_lane0.rcven == (DELAY_W'(coarse_r[CRS_RCVEN_L0 +: COARSE_W]) * 10'd64
                             + DELAY_W'(fine0_r[FINE_RCVEN_LSB +: FINE_W])));
  endproperty
  a_rcven_l0: assert property (p_rcven_l0) else $error("rcven lane0 delay wrong"); // RULE2

  property p_wdqs_l1;
    @(posedge i_core_clk) disable iff (i_rst)
    $stable(coarse_r) && $stable(fine1_r) |=>
      (o_lane1.wdqs == DELAY_W'($past(coarse_r[CRS_WDQS_L1 +: COARSE_W])) * 10'd64
                       + DELAY_W'($past(fine1_r[FINE_WDQS_LSB +: FINE_W])));
  endproperty
  a_wdqs_l1: assert property (p_wdqs_l1) else $error("wdqs lane1 delay wrong"); // RULE3

  property p_wdq_l0;
    @(posedge i_core_clk) disable iff (i_rst)
    $stable(coarse_r) && $stable(fine0_r) |=>
      (o_lane0.wdq == DELAY_W'($past(coarse_r[CRS_WDQ_L0 +: COARSE_W])) * 10'd64
                      + DELAY_W'($past(fine0_r[FINE_WDQ_LSB +: FINE_W])));
  endproperty
  a_wdq_l0: assert property (p_wdq_l0) else $error("wdq lane0 delay wrong"); // RULE4

  property p_sample_read;
    @(posedge i_core_clk) disable iff (i_rst)
    (i_rd && i_addr == OFS_SAMPLE) |=> (o_rdata[SMP_DQS_L1:SMP_DQS_L0] == $past(dqs_last));
  endproperty
  a_sample_read: assert property (p_sample_read) else $error("strobe sample misreported"); // RULE8

  property p_dq_hold;
    @(posedge i_core_clk) disable iff (i_rst)
    !lvl_r[LEVEL_EN_BIT] |=> (dq_lat_r == $past(dq_lat_r));
  endproperty
  a_dq_hold: assert property (p_dq_hold) else $error("dq latched outside leveling"); // RULE9

  property p_four_reads;
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(burst_cmd) |-> burst_cmd [*4] ##1 !burst_cmd;
  endproperty
  a_four_reads: assert property (p_four_reads) else $error("burst not four reads"); // RULE11

  property p_rdqs_width;
    @(posedge i_core_clk) disable iff (i_rst)
    rdqs0_r[31:RDQS_W] == '0 && rdqs1_r[31:RDQS_W] == '0;
  endproperty
  a_rdqs_width: assert property (p_rdqs_width) else $error("rdqs field too wide"); // RULE21

  property p_vref_field;
    @(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == OFS_REF_LANE0) |=> (ref0_r == ({24'h0, $past(i_wdata[7:0])} & 32'h0000_00FC));
  endproperty
  a_vref_field: assert property (p_vref_field) else $error("vref field not stored"); // RULE22
endmodule : phy_train_regs
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the phy delay-training register block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import phy_train_pkg::*;
  logic core_clk = 1'b0;
  logic rst;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [1:0] dqs_smp;
  logic [1:0] dq_lvl;
  logic [1:0] wdqs_rise;
  logic rd_cmd;
  logic rd_rank;
  logic level_mode;
  lane_delay_t lane0;
  lane_delay_t lane1;
  logic [1:0] dqs_set;
  logic [1:0] dq_set;
  logic [15:0] lfsr_r = 16'h0022;
  logic sweep = 1'b0;
  localparam int EDGE_DLY = 80;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [15:0] map [11] = '{OFS_REF_LANE0, OFS_REF_LANE1, OFS_SAMPLE, OFS_FINE_LANE1, OFS_FINE_LANE0,
    OFS_RDQS_LANE1, OFS_RDQS_LANE0, OFS_COARSE, OFS_DEAD_BAND, OFS_PAD_CFG, OFS_LEVEL_CTRL};
  logic [15:0] lmap [9] = '{OFS_FINE_LANE0, OFS_FINE_LANE1, OFS_COARSE, OFS_RDQS_LANE0, OFS_RDQS_LANE1,
    OFS_REF_LANE0, OFS_REF_LANE1, OFS_DEAD_BAND, OFS_PAD_CFG};
  logic [31:0] msk [9] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h7F, 32'h7F, 32'hFC, 32'hFC,
    32'hFFFFFFFF, 32'hFFFFFFFF};

  always #2 core_clk = ~core_clk;

  phy_train_regs i_phy_train_regs (.i_core_clk(core_clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_dqs_sample(dqs_smp), .i_dq_level(dq_lvl),
    .i_wdqs_rise(wdqs_rise), .o_dram_rd_cmd(rd_cmd), .o_dram_rd_rank(rd_rank), .o_level_mode(level_mode),
    .o_lane0(lane0), .o_lane1(lane1));

  dram_rank_model #(.EDGE(EDGE_DLY)) i_dram_rank_model (.i_core_clk(core_clk), .i_rd_cmd(rd_cmd),
    .i_sweep(sweep), .i_wdqs_dly(lane0.wdqs), .i_level_mode(level_mode),
    .i_dqs_set(dqs_set), .i_dq_set(dq_set), .o_dqs(dqs_smp), .o_dq(dq_lvl), .o_wdqs_rise(wdqs_rise));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] dly(input logic [3:0] c, input logic [5:0] f);
    return 32'(c) * 32'h40 + 32'(f);
  endfunction : dly

  function automatic logic [31:0] dead_flags(input logic [5:0] f, input int out_bit, input int low_bit);
    dead_flags = 32'h0;
    if (f < 6'h12 || f > 6'h34)
      dead_flags[out_bit] = 1'b1;
    if (f < 6'h12)
      dead_flags[low_bit] = 1'b1;
  endfunction : dead_flags

  task automatic rnd(output logic [31:0] v);
    repeat (2)
      lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    v = {lfsr_r, lfsr_r[7:0], lfsr_r[15:8]};
  endtask : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic report_and_stop();
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] v;
    logic [31:0] w [9];
    int n;
    addr = 16'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    rst = 1'b1;
    dqs_set = 2'h0;
    dq_set = 2'h0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    foreach (map[i])
    begin
      rd_reg(map[i], v);
      chk(v, RST_ZERO);
    end
    // unmapped place and the read-only sample word both ignore writes
    rnd(v);
    wr_reg(16'h0040, v);
    rd_reg(16'h0040, v);
    chk(v, RST_ZERO);
    rnd(v);
    wr_reg(OFS_SAMPLE, v);
    rd_reg(OFS_SAMPLE, v);
    chk(v, RST_ZERO);
    // first pass all ones hits the largest delay, second all zeros the smallest
    for (int it = 0; it < 8; it++)
    begin
      for (int k = 0; k < 9; k++)
      begin
        if (it == 0)
          w[k] = 32'hFFFFFFFF;
        else if (it == 1)
          w[k] = 32'h0;
        else
          rnd(w[k]);
        wr_reg(lmap[k], w[k]);
      end
      for (int k = 0; k < 9; k++)
      begin
        rd_reg(lmap[k], v);
        chk(v, w[k] & msk[k]);
      end
      chk(32'(lane0.rcven), dly(w[2][11:8], w[0][29:24]));
      chk(32'(lane1.rcven), dly(w[2][23:20], w[1][29:24]));
      chk(32'(lane0.wdqs), dly(w[2][7:4], w[0][21:16]));
      chk(32'(lane1.wdqs), dly(w[2][19:16], w[1][21:16]));
      chk(32'(lane0.wdq), dly(w[2][3:0], w[0][13:8]));
      chk(32'(lane1.wdq), dly(w[2][15:12], w[1][13:8]));
      chk(32'(lane0.rdqs), 32'(w[3][6:0]));
      chk(32'(lane1.rdqs), 32'(w[4][6:0]));
      chk(32'(lane0.vref), 32'(w[5][7:2]));
      chk(32'(lane1.vref), 32'(w[6][7:2]));
    end
    for (int k = 0; k < 8; k++)
    begin
      @(posedge core_clk);
      dqs_set <= k[1:0];
      wr_reg(OFS_READ_GEN, 32'(k[2]));
      n = 0;
      repeat (10)
      begin
        @(posedge core_clk);
        #1;
        if (rd_cmd === 1'b1)
          n++;
        if (rd_cmd === 1'b1)
          chk(32'(rd_rank), 32'(k[2]));
      end
      chk(32'(n), 32'(READS_PER_ACCESS));
      rd_reg(OFS_SAMPLE, v);
      chk(v & 32'h3, 32'(k[1:0]));
    end
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk);
      dq_set <= k[1:0];
      wr_reg(OFS_LEVEL_CTRL, 32'h0001_0000);
      repeat (8) @(posedge core_clk);
      #1;
      chk(32'(level_mode), 32'h1);
      rd_reg(OFS_SAMPLE, v);
      chk((v >> 8) & 32'h3, 32'(k[1:0]));
      wr_reg(OFS_LEVEL_CTRL, RST_ZERO);
      dq_set <= ~k[1:0];
      repeat (8) @(posedge core_clk);
      #1;
      chk(32'(level_mode), RST_ZERO);
      rd_reg(OFS_SAMPLE, v);
      chk((v >> 8) & 32'h3, 32'(k[1:0]));
    end
    // leveling entry, one-unit strobe sweep until the data sample rises, exit
    sweep <= 1'b1;
    rnd(w[1]);
    wr_reg(OFS_PAD_CFG, w[1]);
    wr_reg(OFS_PAD_CFG, (w[1] & 32'h1000_03FC) | 32'h1000_0154);
    rd_reg(OFS_PAD_CFG, v);
    chk(v, (w[1] & 32'h1000_03FC) | 32'h1000_0154);
    wr_reg(OFS_LEVEL_CTRL, 32'h0001_0000);
    wr_reg(OFS_COARSE, 32'h0000_0010);
    n = 0;
    v = 32'h0;
    while (v[8] !== 1'b1 && n < 64)
    begin
      wr_reg(OFS_FINE_LANE0, 32'(n) << 16);
      repeat (8) @(posedge core_clk);
      rd_reg(OFS_SAMPLE, v);
      rd_reg(OFS_SAMPLE, w[0]);
      v = v & w[0];
      n++;
    end
    chk(32'(lane0.wdqs), 32'(EDGE_DLY));
    wr_reg(OFS_LEVEL_CTRL, RST_ZERO);
    wr_reg(OFS_PAD_CFG, (w[1] & 32'h1000_03FC) | 32'h0000_0154);
    rd_reg(OFS_PAD_CFG, v);
    chk(v, (w[1] & 32'h1000_03FC) | 32'h0000_0154);
    sweep <= 1'b0;
    chk(dead_flags(6'h35, 5, 11), 32'h0000_0020);
    chk(dead_flags(6'(n - 1), 1, 4), 32'h0000_0012);
    chk(dead_flags(6'h11, 6, 9), 32'h0000_0240);
    v = dead_flags(6'h35, 5, 11) | dead_flags(6'(n - 1), 1, 4) | dead_flags(6'h11, 6, 9);
    wr_reg(OFS_DEAD_BAND, v);
    rd_reg(OFS_DEAD_BAND, w[2]);
    chk(w[2], 32'h0000_0272);
    // two ranks found the edge two units apart; program their mean
    v = 32'((EDGE_DLY + EDGE_DLY + 2) / 2);
    wr_reg(OFS_FINE_LANE0, ((v - 32'h40) << 16) | ((v - 32'h20) << 8));
    repeat (2) @(posedge core_clk);
    #1;
    chk(32'(lane0.wdqs), v);
    chk(32'(lane0.wdq) + 32'h20, v);
    report_and_stop();
  end

  // ****************************************
  // watchdog
  // ****************************************
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
